// ### src/slsr_top.sv
`timescale 1ns/1ps
// Block lock bits and two-step soft reset inside the flash device
module slsr_top (
    // Core clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    // Serial link pins
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_o,
    // Mode and status inputs from the rest of the device
    input  wire logic        four_line_command_mode_i,
    input  wire logic        write_enable_latch_i,
    input  wire logic        lock_scheme_select_i,
    input  wire logic        protect_complement_i,
    input  wire logic        protect_granularity_i,
    input  wire logic        protect_top_bottom_i,
    input  wire logic [2:0]  protect_range_i,
    // Protection query from erase/program logic
    input  wire logic [23:0] query_addr_i,
    output logic             query_protected_o,
    // Lock state and reset outputs
    output logic [31:0]      lock_bits_o,
    output logic             soft_reset_o,
    output logic             reset_busy_o,
    output logic             reset_armed_o,
    output logic [7:0]       read_parameter_bits_o,
    output logic [7:0]       continuous_read_bits_o,
    output logic [2:0]       wrap_setting_bits_o
);

    // --------------------------------------------------------
    // Link domain state (clocked by sck_i)
    // --------------------------------------------------------
    slsr_pkg::slsr_phase_t phase_reg;      // Frame phase
    logic [5:0]            bit_cnt_reg;    // Bits taken this frame
    logic [7:0]            op_shift_reg;   // Opcode assembly
    logic [23:0]           addr_shift_reg; // Address assembly
    logic [7:0]            cmd_reg;        // Last complete opcode
    logic                  cmd_tog_reg;    // Flips per opcode
    logic                  is_read_reg;    // Frame is a lock read
    logic [2:0]            out_cnt_reg;    // Output beat index
    logic [3:0]            out_reg;        // Driven data bits
    logic                  out_en_reg;     // Output driving
    logic                  frame_rstn;     // Ends frame state
    logic [3:0]            in_bits;        // Bits per rising edge
    logic [5:0]            step;           // 1 or 4
    logic [32:0]           link_view;      // Synced lock bits, busy
    logic                  lock_bit_sel;   // Addressed lock bit
    logic [7:0]            out_byte;       // Lock status byte

    // --------------------------------------------------------
    // Core domain state
    // --------------------------------------------------------
    logic [1:0]  core_view;       // Synced cs_n and toggle
    logic        cs_prev_reg;     // Last synced cs_n
    logic        tog_seen_reg;    // Toggle already handled
    logic        cmd_done;        // Completed opcode at frame end
    logic [31:0] lock_reg;        // Volatile lock bits
    logic        armed_reg;       // Reset enable seen
    logic [11:0] rst_cnt_reg;     // Recovery countdown
    logic        soft_rst_reg;    // One-cycle reset pulse
    logic [7:0]  rdparam_reg;     // Read parameters
    logic [7:0]  contread_reg;    // Continuous-read bits
    logic [2:0]  wrap_reg;        // Wrap setting bits
    logic        prot_reg;        // Registered query answer
    logic        legacy_prot;     // Range based decision
    logic [9:0]  prot_n;          // Units covered by range
    logic [9:0]  unit_idx;        // Unit index of query
    logic [9:0]  unit_total;      // Units in array

    // --------------------------------------------------------
    // Frame reset: chip select high clears frame state
    // --------------------------------------------------------
    assign frame_rstn = rstn_i & ~cs_n_i;

    // Single line uses io[0]; four-line mode takes a nibble
    assign in_bits = four_line_command_mode_i ? io_i
                                              : {3'h0, io_i[0]};
    assign step    = four_line_command_mode_i ? 6'h04 : 6'h01;

    // --------------------------------------------------------
    // Lock bits and busy into the link domain; they only move
    // between frames, so the opcode edges settle the stages
    // --------------------------------------------------------
    slsr_sync #(
        .W    (33),
        .INIT ({1'b0, slsr_pkg::LOCK_RESET})
    ) u_to_link (
        .clk_i  (sck_i),
        .rstn_i (rstn_i),
        .d_i    ({reset_busy_o, lock_reg}),
        .q_o    (link_view)
    );

    // --------------------------------------------------------
    // Frame phase and bit counter, rising edges
    // --------------------------------------------------------
    always_ff @(posedge sck_i or negedge frame_rstn) begin
        if (!frame_rstn) begin
            phase_reg   <= slsr_pkg::SLSR_PH_CMD;
            bit_cnt_reg <= 6'h00;
            is_read_reg <= 1'b0;
        end else begin
            case (phase_reg)
                slsr_pkg::SLSR_PH_CMD: begin
                    bit_cnt_reg <= bit_cnt_reg + step;
                    if (bit_cnt_reg + step == slsr_pkg::OP_BITS) begin
                        // Lock read goes on to its address
                        if ({op_shift_reg[6:0], in_bits[0]} ==
                                slsr_pkg::OP_READ_LOCK &&
                            !four_line_command_mode_i) begin
                            phase_reg   <= slsr_pkg::SLSR_PH_ADDR; // RULE_04
                            is_read_reg <= 1'b1;
                        end else if (four_line_command_mode_i &&
                            {op_shift_reg[3:0], in_bits[3:0]} ==
                                slsr_pkg::OP_READ_LOCK) begin
                            phase_reg   <= slsr_pkg::SLSR_PH_ADDR;
                            is_read_reg <= 1'b1;
                        end else begin
                            phase_reg <= slsr_pkg::SLSR_PH_IDLE;
                        end
                    end
                end
                slsr_pkg::SLSR_PH_ADDR: begin
                    bit_cnt_reg <= bit_cnt_reg + step;
                    if (bit_cnt_reg + step == slsr_pkg::OP_ADDR_BITS) begin
                        phase_reg <= slsr_pkg::SLSR_PH_DATA; // RULE_05
                    end
                end
                default: begin
                    // Data beats and trailing clocks need no count
                    phase_reg <= phase_reg;
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // Opcode and address shifting; not cleared by chip select
    // so the core can still read the opcode after the frame
    // --------------------------------------------------------
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_shift_reg   <= 8'h00;
            addr_shift_reg <= 24'h000000;
        end else if (!cs_n_i) begin
            if (phase_reg == slsr_pkg::SLSR_PH_CMD) begin
                if (four_line_command_mode_i) begin
                    op_shift_reg <= {op_shift_reg[3:0], in_bits};
                end else begin
                    op_shift_reg <= {op_shift_reg[6:0], in_bits[0]};
                end
            end else if (phase_reg == slsr_pkg::SLSR_PH_ADDR) begin
                if (four_line_command_mode_i) begin
                    addr_shift_reg <= {addr_shift_reg[19:0], in_bits};
                end else begin
                    addr_shift_reg <= {addr_shift_reg[22:0], in_bits[0]};
                end
            end
        end
    end

    // --------------------------------------------------------
    // Completed opcode handed to core: word held, toggle flips.
    // Both modes feed here, so reset opcodes work in each.
    // --------------------------------------------------------
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_reg     <= 8'h00;
            cmd_tog_reg <= 1'b0;
        end else if (!cs_n_i && phase_reg == slsr_pkg::SLSR_PH_CMD &&
                     bit_cnt_reg + step == slsr_pkg::OP_BITS) begin
            if (four_line_command_mode_i) begin
                cmd_reg <= {op_shift_reg[3:0], in_bits}; // RULE_11
            end else begin
                cmd_reg <= {op_shift_reg[6:0], in_bits[0]};
            end
            cmd_tog_reg <= ~cmd_tog_reg;
        end
    end

    // --------------------------------------------------------
    // Lock status byte for the addressed block
    // --------------------------------------------------------
    assign lock_bit_sel = link_view[addr_shift_reg[slsr_pkg::BLK_LSB +:
                                                   slsr_pkg::BLK_W]];
    assign out_byte     = {7'h00, lock_bit_sel}; // RULE_06

    // --------------------------------------------------------
    // Output beats on falling edges, MSB first; nothing is
    // driven while a reset is still recovering
    // --------------------------------------------------------
    always_ff @(negedge sck_i or negedge frame_rstn) begin
        if (!frame_rstn) begin
            out_cnt_reg <= 3'h0;
            out_reg     <= 4'h0;
            out_en_reg  <= 1'b0;
        end else if (phase_reg == slsr_pkg::SLSR_PH_DATA &&
                     is_read_reg && !link_view[32]) begin // RULE_13
            out_en_reg  <= 1'b1;
            out_cnt_reg <= out_cnt_reg + 3'h1;
            if (four_line_command_mode_i) begin
                // High nibble first, then low, then repeat
                out_reg <= out_cnt_reg[0] ? out_byte[3:0]
                                          : out_byte[7:4];
            end else begin
                out_reg <= {2'h0, out_byte[3'h7 - out_cnt_reg], 1'b0}; // RULE_05
            end
        end
    end

    // Single line answers on io[1], four-line on all four
    assign io_o    = out_reg;
    assign io_oe_o = !out_en_reg ? 4'h0 :
                     four_line_command_mode_i ? 4'hF : 4'h2;

    // --------------------------------------------------------
    // Core: chip select and toggle brought over
    // --------------------------------------------------------
    slsr_sync #(
        .W    (2),
        .INIT (2'h2)
    ) u_to_core (
        .clk_i  (core_clk_i),
        .rstn_i (rstn_i),
        .d_i    ({cs_n_i, cmd_tog_reg}),
        .q_o    (core_view)
    );

    // Command completes when chip select returns high
    assign cmd_done = !cs_prev_reg && core_view[1] &&
                      (core_view[0] != tog_seen_reg);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_prev_reg  <= 1'b1;
            tog_seen_reg <= 1'b0;
        end else begin
            cs_prev_reg <= core_view[1];
            if (!cs_prev_reg && core_view[1]) begin
                tog_seen_reg <= core_view[0];
            end
        end
    end

    // --------------------------------------------------------
    // Reset arming and recovery countdown
    // --------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed_reg    <= 1'b0;
            rst_cnt_reg  <= 12'h000;
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= 1'b0;
            if (rst_cnt_reg != 12'h000) begin
                // Commands during recovery are dropped
                rst_cnt_reg <= rst_cnt_reg - 12'h001; // RULE_13
            end else if (cmd_done) begin
                if (armed_reg && cmd_reg == slsr_pkg::OP_RST_DEVICE) begin
                    armed_reg    <= 1'b0;
                    soft_rst_reg <= 1'b1; // RULE_12
                    rst_cnt_reg  <= slsr_pkg::RST_COUNT; // RULE_13
                end else begin
                    // Anything but 66h or 99h after 66h disarms
                    armed_reg <= (cmd_reg == slsr_pkg::OP_RST_ENABLE); // RULE_12
                end
            end
        end
    end

    // --------------------------------------------------------
    // Lock bits: set on reset, global lock and unlock
    // --------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_reg <= slsr_pkg::LOCK_RESET; // RULE_03
        end else if (soft_rst_reg) begin
            lock_reg <= slsr_pkg::LOCK_RESET; // RULE_03
        end else if (cmd_done && rst_cnt_reg == 12'h000 &&
                     write_enable_latch_i) begin // RULE_09 RULE_16
            if (cmd_reg == slsr_pkg::OP_GLOBAL_LOCK) begin
                lock_reg <= slsr_pkg::LOCK_RESET; // RULE_07
            end else if (cmd_reg == slsr_pkg::OP_GLOBAL_UNLK) begin
                lock_reg <= 32'h00000000; // RULE_08
            end
        end
    end

    // --------------------------------------------------------
    // Volatile read settings back to defaults on reset
    // --------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdparam_reg  <= slsr_pkg::RDPARAM_RESET; // RULE_15
            contread_reg <= slsr_pkg::CONTREAD_RESET;
            wrap_reg     <= slsr_pkg::WRAP_RESET;
        end else if (soft_rst_reg) begin
            rdparam_reg  <= slsr_pkg::RDPARAM_RESET; // RULE_10 RULE_15
            contread_reg <= slsr_pkg::CONTREAD_RESET; // RULE_10
            wrap_reg     <= slsr_pkg::WRAP_RESET; // RULE_10
        end
    end

    // --------------------------------------------------------
    // Range protection: blocks or sectors from one end, the
    // covered count doubling with each range step
    // --------------------------------------------------------
    always_comb begin
        unit_total = protect_granularity_i ? 10'(slsr_pkg::SECTORS)
                                           : 10'(slsr_pkg::BLOCKS);
        unit_idx   = protect_granularity_i ?
            {1'b0, query_addr_i[slsr_pkg::SEC_LSB +: slsr_pkg::SEC_W]} :
            {5'h00, query_addr_i[slsr_pkg::BLK_LSB +: slsr_pkg::BLK_W]};
        if (protect_range_i == 3'h0) begin
            prot_n = 10'h000;
        end else begin
            prot_n = 10'h001 << (protect_range_i - 3'h1);
        end
        // Sector granularity stops at eight sectors
        if (protect_granularity_i && prot_n > 10'h008) begin
            prot_n = 10'h008;
        end
        if (prot_n > unit_total) begin
            prot_n = unit_total;
        end
        if (protect_top_bottom_i) begin
            legacy_prot = unit_idx < prot_n;
        end else begin
            legacy_prot = unit_idx >= unit_total - prot_n;
        end
        legacy_prot = legacy_prot ^ protect_complement_i; // RULE_02
    end

    // Scheme select picks lock bit or range decision
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prot_reg <= 1'b1;
        end else if (lock_scheme_select_i) begin
            prot_reg <= lock_reg[query_addr_i[slsr_pkg::BLK_LSB +:
                                              slsr_pkg::BLK_W]]; // RULE_01
        end else begin
            prot_reg <= legacy_prot; // RULE_02
        end
    end

    // --------------------------------------------------------
    // Outputs
    // --------------------------------------------------------
    assign query_protected_o      = prot_reg;
    assign lock_bits_o            = lock_reg;
    assign soft_reset_o           = soft_rst_reg; // RULE_10
    assign reset_busy_o           = (rst_cnt_reg != 12'h000);
    assign reset_armed_o          = armed_reg;
    assign read_parameter_bits_o  = rdparam_reg;
    assign continuous_read_bits_o = contread_reg;
    assign wrap_setting_bits_o    = wrap_reg;

endmodule

// ### src/slsr_pkg.sv
// Summary of operation
// RULE_01: Lock bits protect only when scheme select is 1
// RULE_02: Scheme select 0 uses range protect bits instead
// RULE_03: Lock bits volatile, all set after any reset
// RULE_04: Host sends 3Dh then 24-bit address
// RULE_05: Lock byte shifted out MSB first, falling edges
// RULE_06: Byte LSB is 1 locked, 0 unlocked
// RULE_07: Opcode 7Eh sets every lock bit
// RULE_08: Opcode 98h clears every lock bit
// RULE_09: Global lock/unlock need write enable latch set
// RULE_10: Reset restores all volatile defaults
// RULE_11: 66h and 99h work in both command modes
// RULE_12: 99h resets only directly after 66h
// RULE_13: Reset takes 30us, commands ignored meanwhile
// RULE_14: Host should check busy and suspend first
// RULE_15: Defaults: wrap 8 bytes, two dummy clocks
// RULE_16: Global command without write enable is ignored
package slsr_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_READ_LOCK   = 8'h3D;
    localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
    localparam logic [7:0] OP_GLOBAL_UNLK = 8'h98;
    localparam logic [7:0] OP_RST_ENABLE  = 8'h66;
    localparam logic [7:0] OP_RST_DEVICE  = 8'h99;

    // ------------------------------------------------------------
    // Geometry: 64 KB blocks, 4 KB sectors, 24-bit address
    // ------------------------------------------------------------
    localparam int ADDR_W      = 24;
    localparam int BLOCKS      = 32;
    localparam int BLK_W       = 5;
    localparam int BLK_LSB     = 16;
    localparam int SEC_W       = 9;
    localparam int SEC_LSB     = 12;
    localparam int SECTORS     = 512;

    // ------------------------------------------------------------
    // Frame bit counts, shared by both command modes
    // ------------------------------------------------------------
    localparam logic [5:0] OP_BITS       = 6'h08;
    localparam logic [5:0] OP_ADDR_BITS  = 6'h20;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] LOCK_RESET     = 32'hFFFFFFFF;
    localparam logic [7:0]  RDPARAM_RESET  = 8'h00; // 2 dummy, 8-byte wrap
    localparam logic [7:0]  CONTREAD_RESET = 8'h00;
    localparam logic [2:0]  WRAP_RESET     = 3'h1;  // Wrap disabled

    // ------------------------------------------------------------
    // Reset recovery time
    // ------------------------------------------------------------
    localparam int T_RST_NS      = 30000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_CYCLES    = T_RST_NS / CLK_PERIOD_NS;
    localparam logic [11:0] RST_COUNT = 12'(RST_CYCLES);

    // Link-side frame phase
    typedef enum logic [1:0] {
        SLSR_PH_CMD,
        SLSR_PH_ADDR,
        SLSR_PH_DATA,
        SLSR_PH_IDLE
    } slsr_phase_t;

endpackage

// ### src/slsr_sync.sv
`timescale 1ns/1ps
// Two-flop level synchroniser, one stage pair per bit
module slsr_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Destination clock and reset
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    // Levels in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_reg;     // First stage, read only by second

    // --------------------------------------------------------
    // Per-bit synchroniser stages
    // --------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_reg[gi] <= INIT[gi];
                    q_o[gi]      <= INIT[gi];
                end else begin
                    meta_reg[gi] <= d_i[gi];
                    q_o[gi]      <= meta_reg[gi];
                end
            end
        end
    endgenerate

endmodule

// ### bench/slsr_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker: lock bits and two-step soft reset
// ------------------------------------------------------------
module slsr_props (
    // Core clock and reset
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    // Link and mode inputs
    input wire logic        cs_n_i,
    input wire logic        four_line_command_mode_i,
    input wire logic        write_enable_latch_i,
    input wire logic        lock_scheme_select_i,
    input wire logic [23:0] query_addr_i,
    // Watched outputs
    input wire logic [3:0]  io_oe_o,
    input wire logic        query_protected_o,
    input wire logic [31:0] lock_bits_o,
    input wire logic        soft_reset_o,
    input wire logic        reset_busy_o,
    input wire logic        reset_armed_o,
    input wire logic [7:0]  read_parameter_bits_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // Reset effects, allowing for up to two cycles of skew
    sequence s_locked;
        ##[0:2] lock_bits_o == 32'hFFFFFFFF;
    endsequence
    sequence s_busy;
        ##[0:2] reset_busy_o [*8];
    endsequence
    AST_LOCKSET: assert property (soft_reset_o |-> s_locked)
        else $error("soft reset left lock bits clear");
    AST_DEFAULTS: assert property (soft_reset_o |-> ##[0:2]
        read_parameter_bits_o == slsr_pkg::RDPARAM_RESET)
        else $error("read parameters not restored");
    AST_BUSY: assert property (soft_reset_o |-> s_busy)
        else $error("busy not held after soft reset");
    AST_ARMED: assert property (soft_reset_o |-> $past(reset_armed_o) ||
        $past(reset_armed_o, 2) || $past(reset_armed_o, 3))
        else $error("soft reset without armed state");
    AST_SCHEME: assert property (lock_scheme_select_i ##1
        $stable(lock_bits_o) |-> query_protected_o ==
        lock_bits_o[$past(query_addr_i[20:16])])
        else $error("query answer differs from lock bit");
    AST_NOWEL: assert property ((!write_enable_latch_i) [*6] |->
        $stable(lock_bits_o) || lock_bits_o == 32'hFFFFFFFF)
        else $error("lock bits changed without write enable");
    AST_OEIDLE: assert property (cs_n_i [*2] |-> io_oe_o == 4'h0)
        else $error("output enabled outside a frame");
    AST_OEMODE: assert property (io_oe_o != 4'h0 |-> io_oe_o ==
        (four_line_command_mode_i ? 4'hF : 4'h2))
        else $error("output enable wrong for command mode");
endmodule

// ### bench/slsr_host.sv
`timescale 1ns/1ps
// Host controller model: clock idles low, lines toggle when released
module slsr_host (
    // Link outputs
    output logic       sck_o,
    output logic       cs_n_o,
    output logic [3:0] io_o,
    // Resolved pin levels
    input  wire logic [3:0] io_i
);
    initial {sck_o, cs_n_o, io_o} = 6'h10;
    // Opcode, optional address and lock byte, MSB first
    task automatic frame(input logic [7:0] op, input logic rdx,
                         input logic [23:0] a, input logic q,
                         output logic [7:0] rd);
        logic [31:0] sh;
        int          n;
        sh = {op, a};
        n = (rdx ? 32 : 8) / (q ? 4 : 1);
        rd = 8'h00;
        #5 cs_n_o = 1'h0;
        for (int i = 0; i < n; i++) begin
            // Unused lines toggle
            io_o = q ? sh[31:28] : {~io_o[3:1], sh[31]};
            sh = sh << (q ? 4 : 1);
            #27 sck_o = 1'h1;
            #32 sck_o = 1'h0;
            #5;
        end
        for (int i = 0; rdx && i < (q ? 2 : 8); i++) begin
            io_o = ~io_o;
            #27 rd = q ? {rd[3:0], io_i} : {rd[6:0], io_i[1]};
            sck_o = 1'h1;
            #32 sck_o = 1'h0;
            #5;
        end
        cs_n_o = 1'h1;
        io_o = ~io_o;
    endtask
endmodule

// ### bench/tb_sector_lock_and_soft_reset.sv
`timescale 1ns/1ps
// Checker on every block instance
bind slsr_top slsr_props u_props (.*);
module tb_sector_lock_and_soft_reset;
    // Stimulus and observed outputs
    logic        core_clk, rst_n, quad, write_enable_latch, sel, cmp, sck, cs_n;
    logic [3:0]  hio, dio, doe, pin;
    logic [23:0] qaddr;
    logic [31:0] lk;
    logic [7:0]  rd, rp, cr;
    logic [2:0]  wr;
    logic        qp, srst, busy, armed;
    int          failures = 0, n_checks = 0, pulses = 0, nbusy = 0, n;
    // Ordinary frame and the state it should leave
    typedef struct {logic [7:0] op; logic [23:0] a; logic w; logic q;
                    logic [7:0] rd; logic [31:0] lk;} slsr_row_t;
    slsr_row_t rows [7] = '{
        '{8'h3D, 24'h050000, 1'h1, 1'h0, 8'h01, 32'hFFFFFFFF},
        '{8'h98, 24'h000000, 1'h0, 1'h0, 8'h00, 32'hFFFFFFFF},
        '{8'h98, 24'h000000, 1'h1, 1'h1, 8'h00, 32'h00000000},
        '{8'h3D, 24'h1F0000, 1'h0, 1'h1, 8'h00, 32'h00000000},
        '{8'h7E, 24'h000000, 1'h0, 1'h1, 8'h00, 32'h00000000},
        '{8'h7E, 24'h000000, 1'h1, 1'h0, 8'h00, 32'hFFFFFFFF},
        '{8'h3D, 24'h000123, 1'h0, 1'h0, 8'h01, 32'hFFFFFFFF}};
    // Whoever enables a line owns its level
    assign pin = (doe & dio) | (~doe & hio);
    slsr_top DUT (.core_clk_i(core_clk), .rstn_i(rst_n), .sck_i(sck),
        .cs_n_i(cs_n), .io_i(pin), .io_o(dio), .io_oe_o(doe),
        .four_line_command_mode_i(quad), .write_enable_latch_i(write_enable_latch),
        .lock_scheme_select_i(sel), .protect_complement_i(cmp),
        .protect_granularity_i(1'h0), .protect_top_bottom_i(1'h0),
        .protect_range_i(3'h0), .query_addr_i(qaddr),
        .query_protected_o(qp), .lock_bits_o(lk), .soft_reset_o(srst),
        .reset_busy_o(busy), .reset_armed_o(armed),
        .read_parameter_bits_o(rp), .continuous_read_bits_o(cr),
        .wrap_setting_bits_o(wr));
    slsr_host host (.sck_o(sck), .cs_n_o(cs_n), .io_o(hio), .io_i(pin));
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // Counted on the far edge
    always @(negedge core_clk) begin
        pulses += (srst === 1'h1);
        nbusy += (busy === 1'h1);
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One frame, then the gap between frames
    task automatic run(logic [7:0] op, logic [23:0] a, logic w, logic q);
        @(posedge core_clk);
        #1 {write_enable_latch, quad, qaddr} = {w, q, a};
        host.frame(op, op == slsr_pkg::OP_READ_LOCK, a, q, rd);
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    initial begin
        #300000;
        failures++;
        conclude();
    end
    initial begin
        {rst_n, quad, write_enable_latch, sel, cmp, qaddr} = {5'h02, 24'h0};
        repeat (5) @(posedge core_clk);
        #1 chk("reset locks", lk, 32'hFFFFFFFF);
        chk("reset oe", doe, 4'h0);
        rst_n = 1'h1;
        repeat (3) @(posedge core_clk);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].a, rows[i].w, rows[i].q);
            if (rows[i].op == slsr_pkg::OP_READ_LOCK)
                chk("lock byte", rd, rows[i].rd);
            chk("lock bits", lk, rows[i].lk);
            chk("query", qp, rows[i].lk[0]);
            $display("row %0d done", i);
        end
        sel = 1'h0;
        #20 chk("range only", qp, 1'h0);
        cmp = 1'h1;
        #20 chk("complement", qp, 1'h1);
        {sel, cmp} = 2'h2;
        // Broken pair: other command disarms
        run(8'h98, 24'h0, 1'h1, 1'h0);
        run(8'h66, 24'h0, 1'h0, 1'h0);
        chk("armed", armed, 1'h1);
        run(8'h3D, 24'h0, 1'h0, 1'h0);
        chk("disarmed", armed, 1'h0);
        run(8'h99, 24'h0, 1'h0, 1'h0);
        chk("no reset", lk, 32'h0);
        rst_n = 1'h0;
        #20 chk("mid reset", lk, 32'hFFFFFFFF);
        rst_n = 1'h1;
        repeat (3) @(posedge core_clk);
        for (int q = 1; q >= 0; q--) begin
            run(8'h98, 24'h0, 1'h1, q[0]);
            chk("idle", busy, 1'h0);
            run(8'h66, 24'h0, 1'h0, q[0]);
            {pulses, nbusy} = {32'h0, 32'h0};
            run(8'h99, 24'h0, 1'h0, q[0]);
            run(8'h98, 24'h0, 1'h1, q[0]);
            chk("locked", lk, 32'hFFFFFFFF);
            chk("params", {rp, cr, wr}, {slsr_pkg::RDPARAM_RESET,
                slsr_pkg::CONTREAD_RESET, slsr_pkg::WRAP_RESET});
            for (n = 0; busy !== 1'h0 && n < 4000; n++) @(posedge core_clk);
            #1 chk("pulses", pulses, 1);
            chk("busy span", nbusy > 2998 && nbusy < 3002, 1'h1);
            $display("reset pair done, mode %0d", q);
        end
        conclude();
    end
endmodule
